//--- mlcr_regs.v
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mlcr_map.vh"
module mlcr_regs #(
	parameter integer MOD_RST_CYC = (`MLCR_MOD_RST_NS + `MLCR_CLK_NS - 1) / `MLCR_CLK_NS,
	parameter integer CPU_RST_CYC = (`MLCR_CPU_RST_NS + `MLCR_CLK_NS - 1) / `MLCR_CLK_NS
) (
	input  wire        clk_sys_i,
	input  wire        sys_rst_i,
	input  wire [17:0] avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output reg  [31:0] avs_readdata_o,
	output reg         avs_waitrequest_o,
	output reg  [1:0]  avs_response_o,
	input  wire        hw_transmit_off_pin_i,
	input  wire        hw_low_power_pin_i,
	input  wire        prog_control_line_1_i,
	input  wire        prog_control_line_2_i,
	input  wire        prog_control_line_3_i,
	output reg         module_reset_o,
	output reg         cpu_reset_o,
	output reg         low_power_req_o,
	output reg         tx_off_req_o,
	output reg  [2:0]  prog_ctrl_sw_o,
	output reg         global_alarm_out_o,
	output reg  [15:0] lane_tx_off_o,
	output reg         prbs_gen_en_o,
	output reg  [1:0]  prbs_len_sel_o,
	output reg         deskew_off_o,
	output reg         tx_fifo_rst_o,
	output reg         tx_fifo_auto_rst_o,
	output reg         tx_path_rst_o,
	output reg  [2:0]  mclk_sel_o,
	output reg  [2:0]  lane_rate_sel_o,
	output reg         refclk_div64_o
);

////////////////////////////////////////////////////////////////////////////////
// Overview of the bank.
//
// Three 16-bit words sit in the low half of the 32-bit bus word.
// The word index is the byte address shifted right by two.
// Any other index answers with a decode error and changes nothing.
//
// General control word:
//   bit 15     module reset request; a 1 starts a timed pulse, a 0 does nothing.
//   bit 14     software low power request, a plain level.
//   bit 13     software transmitter disable request, a plain level.
//   bits 12:10 software copies of programmable controls 3, 2 and 1.
//   bit 9      alarm test; forces the global alarm output while set.
//   bit 8      processor reset request; a 1 starts a shorter timed pulse.
//   bits 7:6   reserved, read as zero.
//   bits 5:4   synchronised transmit-off and low-power pin levels.
//   bits 3:1   synchronised programmable control pin levels 3 to 1.
//   bit 0      reserved, read as zero.
//
// Lane-off word:
//   bit n      holds network lane n quiet when set.
//   The word only feeds the lane outputs, so it never disturbs any
//   module-level state kept elsewhere.
//
// Transmit control word:
//   bit 15     reserved, read as zero.
//   bit 14     pattern generator replaces data on all network lanes.
//   bits 13:12 pattern length selector, four choices.
//   bit 11     de-skew off.
//   bit 10     transmit FIFO reset on host and network sides.
//   bit 9      automatic FIFO reset enable; comes out of reset set.
//   bit 8      holds the transmit path in reset.
//   bits 7:5   monitor clock divider code.
//   bit 4      reserved, read as zero.
//   bits 3:1   network lane rate code.
//   bit 0      reference clock ratio, 1/16 when clear and 1/64 when set.
//
// Pulsed bits:
//   Only the module reset request reads back as 1 while its pulse runs, so
//   software can poll it for completion; the processor reset bit reads as zero.
//   Writing 1 again while a pulse runs reloads the counter and stretches it.
//   A write to the level bits in the same cycle as a pulse ends does not
//   hold the pulse bit up, because the pulse logic owns those two bits.
//
// Reserved codes:
//   Reserved monitor clock and rate codes are stored and read back as
//   written, but the outputs see code zero so no clock tree is ever steered
//   to a setting that the far side does not support.
//
// Bus timing:
//   A request is taken on the first edge it is seen, waitrequest drops for
//   exactly one cycle after that edge, and the write lands on that first
//   edge, one cycle before the master sees waitrequest low.
//   The ack flag blocks the held request from being taken twice.
//
// Outputs:
//   Every output comes from a flop, one cycle behind the stored bit, so the
//   far side never sees decode glitches.
//
// Pins:
//   The five pins are asynchronous and pass two flops before any read.
//   The readback therefore lags a pin change by two to three cycles.

////////////////////////////////////////////////////////////////////////////////
// Storage and helpers.

reg [15:0] gen_r;
reg [15:0] tx_r;
reg [15:0] lane_r;
reg [4:0]  pin_s1_r;
reg [4:0]  pin_s2_r;
reg [15:0] mod_cnt_r;
reg [15:0] cpu_cnt_r;
reg        ack_r;
reg [15:0] rdata_nxt;
reg        hit_nxt;
wire       req_w;
wire [15:0] idx_w;
wire [15:0] be_mask_w;
wire [15:0] wd_w;
wire       wr_gen_w;
wire       wr_tx_w;
wire       wr_lane_w;
wire       mod_set_w;
wire       cpu_set_w;

assign req_w     = (avs_read_i | avs_write_i) & ~ack_r;
assign idx_w     = avs_address_i[17:2];
assign be_mask_w = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
assign wd_w      = avs_writedata_i[15:0];

// Write strobes per register and the two pulse starts.
assign wr_gen_w  = req_w & avs_write_i & (idx_w == `MLCR_IDX_GEN_CTRL);
assign wr_tx_w   = req_w & avs_write_i & (idx_w == `MLCR_IDX_TX_CTRL);
assign wr_lane_w = req_w & avs_write_i & (idx_w == `MLCR_IDX_LANE_OFF);
assign mod_set_w = wr_gen_w & avs_byteenable_i[1] & wd_w[`MLCR_GEN_MOD_RST];
assign cpu_set_w = wr_gen_w & avs_byteenable_i[1] & wd_w[`MLCR_GEN_CPU_RST];

// Merges enabled byte lanes of the write into the old value, writable bits only.
function [15:0] mlcr_merge;
	input [15:0] old_v;
	input [15:0] new_v;
	input [15:0] lanes;
	input [15:0] wmask;
	begin
		mlcr_merge = (old_v & ~(lanes & wmask)) | (new_v & lanes & wmask);
	end
endfunction

// Folds reserved divider codes to disabled so the clock tree never sees them.
function [2:0] mlcr_mclk_ok;
	input [2:0] code;
	begin
		case (code)
			3'h1, 3'h2, 3'h5, 3'h7: mlcr_mclk_ok = code;
			default: mlcr_mclk_ok = 3'h0;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: two flops before anything reads the pins.

always @(posedge clk_sys_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		pin_s1_r <= 5'h00;
		pin_s2_r <= 5'h00;
	end else begin
		pin_s1_r <= {hw_transmit_off_pin_i, hw_low_power_pin_i, prog_control_line_3_i,
			prog_control_line_2_i, prog_control_line_1_i};
		pin_s2_r <= pin_s1_r;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read decode.

always @* begin
	rdata_nxt = 16'h0000;
	hit_nxt   = 1'b1;
	case (idx_w)
		`MLCR_IDX_GEN_CTRL: begin
			rdata_nxt = gen_r & `MLCR_GEN_WR_MASK;
			rdata_nxt[`MLCR_GEN_PIN_TXOFF:`MLCR_GEN_PIN_PRG1] = pin_s2_r;
		end
		`MLCR_IDX_TX_CTRL:  rdata_nxt = tx_r & `MLCR_TX_WR_MASK;
		`MLCR_IDX_LANE_OFF: rdata_nxt = lane_r;
		default: hit_nxt = 1'b0;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Bus slave: one wait cycle, answer on the second edge of a request.

always @(posedge clk_sys_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		ack_r             <= 1'b0;
		avs_waitrequest_o <= 1'b1;
		avs_readdata_o    <= 32'h00000000;
		avs_response_o    <= 2'h0;
	end else begin
		ack_r             <= req_w;
		avs_waitrequest_o <= ~req_w;
		if (req_w) begin
			avs_readdata_o <= avs_read_i ? {16'h0000, rdata_nxt} : 32'h00000000;
			avs_response_o <= hit_nxt ? 2'h0 : 2'h3;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Pulse hold counters.

// Loads on a 1 written to the module reset bit and counts the hold time down.
always @(posedge clk_sys_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		mod_cnt_r <= 16'h0000;
	end else if (mod_set_w) begin
		mod_cnt_r <= MOD_RST_CYC[15:0];
	end else if (mod_cnt_r != 16'h0000) begin
		mod_cnt_r <= mod_cnt_r - 16'h0001;
	end
end

// Loads on a 1 written to the processor reset bit and counts the hold time down.
always @(posedge clk_sys_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		cpu_cnt_r <= 16'h0000;
	end else if (cpu_set_w) begin
		cpu_cnt_r <= CPU_RST_CYC[15:0];
	end else if (cpu_cnt_r != 16'h0000) begin
		cpu_cnt_r <= cpu_cnt_r - 16'h0001;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Register writes.

// General control: level bits follow writes; the pulse logic alone owns bits 15 and 8.
always @(posedge clk_sys_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		gen_r <= `MLCR_RST_GEN_CTRL;
	end else begin
		if (wr_gen_w) begin
			gen_r <= mlcr_merge(gen_r, wd_w, be_mask_w, `MLCR_GEN_LVL_MASK);
		end
		if (mod_set_w) begin
			gen_r[`MLCR_GEN_MOD_RST] <= 1'b1;
		end else if (mod_cnt_r == 16'h0001) begin
			gen_r[`MLCR_GEN_MOD_RST] <= 1'b0;
		end
		if (cpu_set_w) begin
			gen_r[`MLCR_GEN_CPU_RST] <= 1'b1;
		end else if (cpu_cnt_r == 16'h0001) begin
			gen_r[`MLCR_GEN_CPU_RST] <= 1'b0;
		end
	end
end

// Transmit control: writable fields only, reserved bits stay zero.
always @(posedge clk_sys_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		tx_r <= `MLCR_RST_TX_CTRL;
	end else if (wr_tx_w) begin
		tx_r <= mlcr_merge(tx_r, wd_w, be_mask_w, `MLCR_TX_WR_MASK);
	end
end

// Lane-off word: touches nothing but the lane outputs.
always @(posedge clk_sys_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		lane_r <= `MLCR_RST_LANE_OFF;
	end else if (wr_lane_w) begin
		lane_r <= mlcr_merge(lane_r, wd_w, be_mask_w, `MLCR_LANE_WR_MASK);
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control outputs, registered from the stored fields.

// General control outputs.
always @(posedge clk_sys_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		module_reset_o     <= 1'b0;
		cpu_reset_o        <= 1'b0;
		low_power_req_o    <= 1'b0;
		tx_off_req_o       <= 1'b0;
		prog_ctrl_sw_o     <= 3'h0;
		global_alarm_out_o <= 1'b0;
	end else begin
		module_reset_o     <= gen_r[`MLCR_GEN_MOD_RST];
		cpu_reset_o        <= gen_r[`MLCR_GEN_CPU_RST];
		low_power_req_o    <= gen_r[`MLCR_GEN_LOW_PWR];
		tx_off_req_o       <= gen_r[`MLCR_GEN_TX_OFF];
		prog_ctrl_sw_o     <= gen_r[`MLCR_GEN_PRG3:`MLCR_GEN_PRG1];
		global_alarm_out_o <= gen_r[`MLCR_GEN_ALM_TEST];
	end
end

// Per-lane transmit disables.
always @(posedge clk_sys_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		lane_tx_off_o <= 16'h0000;
	end else begin
		lane_tx_off_o <= lane_r;
	end
end

// Transmit control outputs; reserved codes reach the far side as zero.
always @(posedge clk_sys_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		prbs_gen_en_o      <= 1'b0;
		prbs_len_sel_o     <= 2'h0;
		deskew_off_o       <= 1'b0;
		tx_fifo_rst_o      <= 1'b0;
		tx_fifo_auto_rst_o <= 1'b1;
		tx_path_rst_o      <= 1'b0;
		mclk_sel_o         <= 3'h0;
		lane_rate_sel_o    <= 3'h0;
		refclk_div64_o     <= 1'b0;
	end else begin
		prbs_gen_en_o      <= tx_r[`MLCR_TX_PRBS_EN];
		prbs_len_sel_o     <= tx_r[`MLCR_TX_PRBS_HI:`MLCR_TX_PRBS_LO];
		deskew_off_o       <= tx_r[`MLCR_TX_DESKEW_OFF];
		tx_fifo_rst_o      <= tx_r[`MLCR_TX_FIFO_RST];
		tx_fifo_auto_rst_o <= tx_r[`MLCR_TX_FIFO_AUTO];
		tx_path_rst_o      <= tx_r[`MLCR_TX_PATH_RST];
		mclk_sel_o         <= mlcr_mclk_ok(tx_r[`MLCR_TX_MCLK_HI:`MLCR_TX_MCLK_LO]);
		lane_rate_sel_o    <= (tx_r[`MLCR_TX_RATE_HI:`MLCR_TX_RATE_HI-1] == 2'h3)
			? 3'h0 : tx_r[`MLCR_TX_RATE_HI:`MLCR_TX_RATE_LO];
		refclk_div64_o     <= tx_r[`MLCR_TX_REFCLK_SEL];
	end
end

endmodule
`default_nettype wire

//--- mlcr_map.vh
`ifndef MLCR_MAP_VH
`define MLCR_MAP_VH
// Register word indices; byte address is four times the index.
`define MLCR_IDX_GEN_CTRL    16'hb010
`define MLCR_IDX_TX_CTRL     16'hb011
`define MLCR_IDX_LANE_OFF    16'hb013
// Reset values.
`define MLCR_RST_GEN_CTRL    16'h0000
`define MLCR_RST_TX_CTRL     16'h0200
`define MLCR_RST_LANE_OFF    16'h0000
// General control bit positions.
`define MLCR_GEN_MOD_RST     15
`define MLCR_GEN_LOW_PWR     14
`define MLCR_GEN_TX_OFF      13
`define MLCR_GEN_PRG3        12
`define MLCR_GEN_PRG2        11
`define MLCR_GEN_PRG1        10
`define MLCR_GEN_ALM_TEST    9
`define MLCR_GEN_CPU_RST     8
`define MLCR_GEN_PIN_TXOFF   5
`define MLCR_GEN_PIN_LOPWR   4
`define MLCR_GEN_PIN_PRG3    3
`define MLCR_GEN_PIN_PRG1    1
// Writable masks; reserved and read-only bits are excluded.
`define MLCR_GEN_WR_MASK     16'hfe00
`define MLCR_TX_WR_MASK      16'h7fef
// Level bits of general control that follow a write directly.
`define MLCR_GEN_LVL_MASK    16'h7e00
// Every lane-off bit is writable.
`define MLCR_LANE_WR_MASK    16'hffff
// Transmit control bit positions.
`define MLCR_TX_PRBS_EN      14
`define MLCR_TX_PRBS_HI      13
`define MLCR_TX_PRBS_LO      12
`define MLCR_TX_DESKEW_OFF   11
`define MLCR_TX_FIFO_RST     10
`define MLCR_TX_FIFO_AUTO    9
`define MLCR_TX_PATH_RST     8
`define MLCR_TX_MCLK_HI      7
`define MLCR_TX_MCLK_LO      5
`define MLCR_TX_RATE_HI      3
`define MLCR_TX_RATE_LO      1
`define MLCR_TX_REFCLK_SEL   0
// Timing of the pulsed resets.
`define MLCR_MOD_RST_NS      1000
`define MLCR_CPU_RST_NS      500
`define MLCR_CLK_NS          100
`endif

//--- mlcr_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Watches bus timing, decode and control outputs of the register bank.
module mlcr_regs_properties #(
	parameter integer MOD_RST_CYC = 10,
	parameter integer CPU_RST_CYC = 5
) (
	input wire logic        clk_sys_i,
	input wire logic        sys_rst_i,
	input wire logic [17:0] avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0]  avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        module_reset_o,
	input wire logic        cpu_reset_o,
	input wire logic        global_alarm_out_o,
	input wire logic [15:0] lane_tx_off_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// Answer cycle and decoded register index.
	wire        ans = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
	wire [15:0] idx = avs_address_i[17:2];
	wire        wgen = ans & avs_write_i & (idx == 16'hb010) & avs_byteenable_i[1];
	wait_one_a: assert property ((avs_read_i | avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("request not answered next cycle");
	alarm_test_a: assert property (wgen |-> ##2 global_alarm_out_o ==
		$past(avs_writedata_i[9], 2)) else $error("alarm test output wrong");
	mod_start_a: assert property (wgen && !module_reset_o |-> ##2
		module_reset_o == $past(avs_writedata_i[15], 2)) else $error("module reset start wrong");
	mod_len_a: assert property ($fell(module_reset_o) |-> $past(module_reset_o, MOD_RST_CYC)
		&& !$past(module_reset_o, MOD_RST_CYC + 1)) else $error("module reset length wrong");
	cpu_len_a: assert property ($fell(cpu_reset_o) |-> $past(cpu_reset_o, CPU_RST_CYC)
		&& !$past(cpu_reset_o, CPU_RST_CYC + 1)) else $error("processor reset length wrong");
	lane_off_a: assert property (ans && avs_write_i && idx == 16'hb013 &&
		avs_byteenable_i[1:0] == 2'b11 |-> ##2 lane_tx_off_o == $past(avs_writedata_i[15:0], 2))
		else $error("lane disable output wrong");
	lane_read_a: assert property (ans && avs_read_i && idx == 16'hb013 |->
		avs_readdata_o == {16'h0000, lane_tx_off_o}) else $error("lane readback wrong");
	rsvd_read_a: assert property (ans && avs_read_i && idx == 16'hb010 |->
		avs_readdata_o[7:6] == 2'b00 && !avs_readdata_o[0]) else $error("reserved bits not zero");
	cover property (wgen && avs_writedata_i[15]);
	cover property (wgen && avs_writedata_i[8]);
	cover property (ans && avs_read_i && idx == 16'hb011);
endmodule
`default_nettype wire

//--- mlcr_host.sv
`timescale 1ns/1ps
`default_nettype none
// Management host issuing one Avalon transfer at a time.
module mlcr_host (
	input  wire logic        clk_i,
	input  wire logic        wait_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  resp_i,
	output var  logic [17:0] addr_o,
	output var  logic        rd_o,
	output var  logic        wr_o,
	output var  logic [31:0] wdata_o,
	output var  logic [3:0]  be_o
);
	logic hung = 1'b0;
	// Idle bus at time zero.
	initial begin
		{addr_o, rd_o, wr_o, wdata_o, be_o} = '0;
	end
	// Hold the request until waitrequest is seen low, then scramble the released lines.
	task automatic xfer(input logic rd, input logic [17:0] a, input logic [31:0] d,
		input logic [3:0] b, output logic [31:0] q, output logic [1:0] r);
		int n;
		@(posedge clk_i);
		{addr_o, rd_o, wr_o, wdata_o, be_o} <= {a, rd, !rd, d, b};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wait_i && n < 50);
		hung = wait_i;
		q = rdata_i;
		r = resp_i;
		{addr_o, rd_o, wr_o, wdata_o} <= {~a, 2'b00, ~d};
	endtask
endmodule
`default_nettype wire

//--- mlcr_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module mlcr_regs_test;
	logic        clk_sys_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [4:0]  pv = 5'h00;
	wire  [17:0] avs_address_i;
	wire  [31:0] avs_writedata_i, avs_readdata_o;
	wire  [3:0]  avs_byteenable_i;
	wire  [1:0]  avs_response_o, prbs_len_sel_o;
	wire         avs_read_i, avs_write_i, avs_waitrequest_o, module_reset_o, cpu_reset_o;
	wire         hw_transmit_off_pin_i, hw_low_power_pin_i, prog_control_line_1_i;
	wire         prog_control_line_2_i, prog_control_line_3_i, low_power_req_o, tx_off_req_o;
	wire         global_alarm_out_o, prbs_gen_en_o, deskew_off_o, tx_fifo_rst_o, refclk_div64_o;
	wire         tx_fifo_auto_rst_o, tx_path_rst_o;
	wire  [2:0]  prog_ctrl_sw_o, mclk_sel_o, lane_rate_sel_o;
	wire  [15:0] lane_tx_off_o;
	int          err_count = 0;
	int          num_checks = 0;
	logic [31:0] seed = 32'h0e84e765, q;
	logic [1:0]  r;
	logic [15:0] mdl [4] = '{16'h0000, 16'h0200, 16'h0000, 16'h0000};
	logic [15:0] wm [4] = '{16'h7e00, 16'h7fef, 16'h0000, 16'hffff};
	assign {hw_transmit_off_pin_i, hw_low_power_pin_i, prog_control_line_3_i} = pv[4:2];
	assign {prog_control_line_2_i, prog_control_line_1_i} = pv[1:0];
	mlcr_regs #(.MOD_RST_CYC(2), .CPU_RST_CYC(2)) i_mlcr_regs (.*);
	mlcr_host i_mlcr_host (.clk_i(clk_sys_i), .wait_i(avs_waitrequest_o),
		.rdata_i(avs_readdata_o), .resp_i(avs_response_o), .addr_o(avs_address_i),
		.rd_o(avs_read_i), .wr_o(avs_write_i), .wdata_o(avs_writedata_i), .be_o(avs_byteenable_i));
	// Clock of 100 ns period.
	always #50 clk_sys_i = ~clk_sys_i;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic rd, input int i, input logic [15:0] d, input logic [1:0] b);
		i_mlcr_host.xfer(rd, 18'h2c040 + 18'(i * 4), {16'h0000, d}, {2'b00, b}, q, r);
		if (i_mlcr_host.hung) begin
			err_count++;
			complete_run();
		end
	endtask
	// Reads one word and compares data and response with the model.
	task automatic rd_chk(input int i);
		bus(1'b1, i, 16'h0000, 2'b11);
		chk("read data", {16'h0000, mdl[i] | (i == 0 ? {10'h000, pv, 1'b0} : 16'h0)}, q);
		chk("read resp", i == 2 ? 2'b11 : 2'b00, r);
	endtask
	// Compares every control output with the model registers.
	task automatic outs();
		logic [2:0] c;
		c = mdl[1][7:5];
		chk("gen outs", {2'b00, mdl[0][14:9]}, {module_reset_o, cpu_reset_o, low_power_req_o, tx_off_req_o, prog_ctrl_sw_o, global_alarm_out_o});
		chk("tx outs", mdl[1][14:8], {prbs_gen_en_o, prbs_len_sel_o, deskew_off_o, tx_fifo_rst_o, tx_fifo_auto_rst_o, tx_path_rst_o});
		chk("mclk", (c == 1 || c == 2 || c == 5 || c == 7) ? c : 3'd0, mclk_sel_o);
		chk("rate", mdl[1][3:1] < 6 ? mdl[1][3:1] : 3'd0, lane_rate_sel_o);
		chk("refclk", mdl[1][0], refclk_div64_o);
		chk("lanes", mdl[3], lane_tx_off_o);
	endtask
	initial begin
		int i;
		logic [15:0] d, k;
		logic [1:0] b;
		repeat (10) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		for (i = 0; i < 4; i++) rd_chk(i);
		outs();
		$display("reset value test done");
		for (int n = 0; n < 48; n++) begin
			seed = lfsr(seed);
			i = n < 8 ? 1 : int'(seed[1:0]);
			b = n < 8 ? 2'b11 : seed[3:2];
			d = n < 8 ? (seed[31:16] & 16'h7f11) | 16'(n << 5) | 16'(n << 1) : seed[31:16];
			d = d & (i == 0 ? 16'h7eff : 16'hffff);
			k = {{8{b[1]}}, {8{b[0]}}} & wm[i];
			bus(1'b0, i, d, b);
			mdl[i] = (mdl[i] & ~k) | (d & k);
			chk("write resp", i == 2 ? 2'b11 : 2'b00, r);
			pv <= seed[8:4];
			repeat (3) @(posedge clk_sys_i);
			rd_chk(i);
			outs();
		end
		$display("random write test done");
		for (int j = 0; j < 2; j++) begin
			bus(1'b0, 0, mdl[0] | (j ? 16'h8000 : 16'h0100), 2'b11);
			@(posedge clk_sys_i);
			#1 chk("reset pulse", j ? 2'b10 : 2'b01, {module_reset_o, cpu_reset_o});
			repeat (8) @(posedge clk_sys_i);
			rd_chk(0);
			outs();
		end
		$display("reset pulse test done");
		complete_run();
	end
endmodule
bind mlcr_regs mlcr_regs_properties #(.MOD_RST_CYC(MOD_RST_CYC), .CPU_RST_CYC(CPU_RST_CYC))
	i_mlcr_regs_properties (.*);
`default_nettype wire
